// ===== dv/flash_cmd_seq_properties.sv
// port checks for the status and read command sequencer
// assumes binding into flash_cmd_seq, one clock, synchronous reset
`timescale 1ns/1ps
module flash_cmd_seq_properties #(
   parameter int STATUS_WRITE_CYCLES = 20
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // watched ports
   input wire logic cs_n,
   input wire logic [3:0] io_oe,
   input wire logic mem_rd,
   input wire logic array_busy,
   input wire logic busy,
   input wire logic write_enable_latch,
   input wire logic quad_enable,
   input wire logic [7:0] status_reg1,
   input wire logic [7:0] status_reg2,
   input wire logic [7:0] status_reg3
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   int wait_reg;
   // busy cycles of a stored write; array work spoils the count, so it restarts
   always_ff @(posedge sys_clk) begin
      wait_reg <= (reset || !busy || array_busy) ? 0 : wait_reg + 1;
   end
   sequence s_write_done;
      $fell(busy) && !$past(array_busy);
   endsequence
   a_write_time: assert property (s_write_done |-> wait_reg == STATUS_WRITE_CYCLES)
      else $error("write time off");
   a_latch_cleared: assert property (s_write_done |=> !write_enable_latch)
      else $error("latch kept");
   a_array_busy: assert property (array_busy |-> busy)
      else $error("busy low");
   a_latch_deselect: assert property ($rose(write_enable_latch) |-> cs_n)
      else $error("latch bit");
   a_busy_shown: assert property (status_reg1[0] == busy)
      else $error("busy bit");
   a_qe_shown: assert property (status_reg2[1] == quad_enable)
      else $error("quad bit");
   a_ro_fixed: assert property ($stable({status_reg2[7], status_reg2[2],
      status_reg3[4:3], status_reg3[0]})) else $error("fixed bit moved");
   a_idle_quiet: assert property (cs_n [*5] |-> io_oe == 4'h0)
      else $error("idle drive");
   a_quad_qe: assert property (|io_oe[3:2] |-> quad_enable)
      else $error("quad drive");
   a_lane_set: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("lane enables");
   a_fetch_pulse: assert property (mem_rd |=> !mem_rd)
      else $error("fetch pulse");
endmodule : flash_cmd_seq_properties

bind flash_cmd_seq flash_cmd_seq_properties #(
   .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) i_props (
   .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .io_oe(io_oe), .mem_rd(mem_rd),
   .array_busy(array_busy), .busy(busy), .write_enable_latch(write_enable_latch),
   .quad_enable(quad_enable), .status_reg1(status_reg1), .status_reg2(status_reg2),
   .status_reg3(status_reg3));

// ===== dv/flash_cmd_seq_tb.sv
// self-checking bench for the status and read command sequencer
// assumes the host model and checker are compiled first
`timescale 1ns/1ps
module flash_cmd_seq_tb;
   import flash_pkg::*;
   typedef struct packed {
      logic [7:0] op;
      logic [23:0] addr;
      logic [2:0] lanes;
   } row_t;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic array_busy = 1'b0;
   logic array_done = 1'b0;
   logic soft_reset = 1'b0;
   logic [7:0] mem_rdata = 8'h00;
   logic mem_rd, busy, write_enable_latch, quad_enable, spi_clk, cs_n, oe_seen;
   logic [7:0] status_reg1, status_reg2, status_reg3;
   logic [3:0] io_in, io_out, io_oe;
   logic [23:0] mem_addr;
   logic [31:0] d;
   int fail_count = 0;
   int samples_checked = 0;
   row_t rows [4];
   always #10 sys_clk = ~sys_clk;
   flash_cmd_seq #(.STATUS_WRITE_CYCLES(1000)) i_dut (
      .sys_clk(sys_clk), .reset(reset), .spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata), .array_busy(array_busy), .array_done(array_done),
      .soft_reset(soft_reset), .busy(busy), .write_enable_latch(write_enable_latch),
      .quad_enable(quad_enable), .status_reg1(status_reg1), .status_reg2(status_reg2),
      .status_reg3(status_reg3));
   spi_host_model i_host (
      .spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
   function automatic logic [7:0] mem_byte(input logic [23:0] a);
      mem_byte = a[7:0] ^ a[23:16] ^ 8'hA5;
   endfunction : mem_byte
   // array stand-in answers a cycle after the fetch; any drive is noted
   always @(posedge sys_clk) begin
      if (mem_rd === 1'b1) mem_rdata <= mem_byte(mem_addr);
      if (io_oe !== 4'h0) oe_seen <= 1'b1;
   end
   task check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // frames end on a falling edge so checks never race the design
   task cmd(input logic [31:0] v, input int n);
      i_host.frame_start();
      i_host.send(v, n);
      i_host.frame_end();
      @(negedge sys_clk);
   endtask : cmd
   task rd_sr(input logic [7:0] op, input logic [7:0] exp);
      i_host.frame_start();
      i_host.send({24'h0, op}, 8);
      i_host.recv(1, 16, d);
      cmd(32'h0, 0);
      check(d[15:8], exp);
      check(d[7:0], exp);
   endtask : rd_sr
   task rd_frame(input row_t r);
      i_host.frame_start();
      i_host.send({r.op, r.addr}, 32);
      if (r.op != OP_READ) i_host.recv(1, 8, d);
      i_host.recv(int'(r.lanes), 16 / int'(r.lanes), d);
      cmd(32'h0, 0);
   endtask : rd_frame
   task complete_run();
      if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   // about 120 microseconds expected; this cuts a hang
   initial begin
      #1_000_000;
      fail_count++;
      complete_run();
   end
   initial begin
      rows[0] = '{OP_READ, 24'h000010, LANE_SINGLE};
      rows[1] = '{OP_FREAD, 24'hFFFFFF, LANE_SINGLE};
      rows[2] = '{OP_DREAD, 24'h123456, LANE_DUAL};
      rows[3] = '{OP_QREAD, 24'h00ABCD, LANE_QUAD};
      oe_seen = 1'b0;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (4) @(negedge sys_clk);
      check({7'h0, write_enable_latch}, 8'h00);
      rd_sr(OP_RDSR1, 8'h00);
      rd_sr(OP_RDSR2, 8'h00);
      rd_sr(OP_RDSR3, 8'h60);
      cmd(OP_WREN, 8);
      rd_sr(OP_RDSR1, 8'h02);
      cmd(OP_WRDI, 8);
      check({7'h0, write_enable_latch}, 8'h00);
      cmd(OP_VWREN, 8);
      check({7'h0, write_enable_latch}, 8'h00);
      cmd({OP_WRSR2, 8'hFF}, 16);
      check(status_reg2, 8'h7B);
      cmd(OP_VWREN, 8);
      cmd({OP_WRSR1, 8'h0F}, 16);
      check(status_reg1, 8'h0C);
      check(status_reg2, 8'h7B);
      for (int i = 0; i < 4; i++) begin
         rd_frame(rows[i]);
         check(d[15:8], mem_byte(rows[i].addr));
         check(d[7:0], mem_byte(rows[i].addr + 24'h1));
      end
      cmd(OP_VWREN, 8);
      cmd({OP_WRSR2, 8'h00}, 16);
      check(status_reg2, 8'h39);
      oe_seen = 1'b0;
      rd_frame(rows[3]);
      check({7'h0, oe_seen}, 8'h00);
      cmd(OP_WREN, 8);
      cmd({OP_WRSR1, 8'hFF, 8'h02}, 24);
      check({7'h0, busy}, 8'h01);
      rd_sr(OP_RDSR1, 8'h0F);
      oe_seen = 1'b0;
      rd_frame(rows[0]);
      check({7'h0, oe_seen}, 8'h00);
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge sys_clk);
      @(negedge sys_clk);
      check({7'h0, write_enable_latch}, 8'h00);
      check(status_reg1, 8'hFC);
      check({7'h0, quad_enable}, 8'h01);
      cmd(OP_WREN, 8);
      @(posedge sys_clk) array_done <= 1'b1;
      @(posedge sys_clk) array_done <= 1'b0;
      cmd(32'h0, 0);
      check({7'h0, write_enable_latch}, 8'h00);
      @(posedge sys_clk) array_busy <= 1'b1;
      rd_sr(OP_RDSR1, 8'hFD);
      @(posedge sys_clk) array_busy <= 1'b0;
      cmd(OP_VWREN, 8);
      cmd({OP_WRSR1, 8'h00}, 16);
      check(status_reg1, 8'h00);
      @(posedge sys_clk) soft_reset <= 1'b1;
      @(posedge sys_clk) soft_reset <= 1'b0;
      cmd(32'h0, 0);
      check(status_reg1, 8'hFC);
      cmd(OP_WREN, 7);
      check({7'h0, write_enable_latch}, 8'h00);
      complete_run();
   end
endmodule : flash_cmd_seq_tb

// ===== dv/spi_host_model.sv
// serial host model: select, clock and IO0 out, device lanes captured
// assumes mode 0 at 160 ns a serial clock; the bench calls its tasks
`timescale 1ns/1ps
module spi_host_model (
   // serial pins toward the device
   output logic spi_clk,
   output logic cs_n,
   output logic [3:0] io_in,
   // device drive
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe
);
   logic [3:0] drv = 4'h0;
   logic [3:0] host_oe = 4'h0;
   logic junk = 1'b0;
   initial begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
   end
   // released lines wander, so a stale level never passes for data
   always #30 junk = ~junk;
   assign io_in = (io_oe & io_out) | (~io_oe & host_oe & drv) | (~io_oe & ~host_oe & {4{junk}});
   task frame_start();
      cs_n = 1'b0;
      #160;
   endtask : frame_start
   // bits go out MSB first, changed while the clock is low
   task send(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         host_oe = 4'h1;
         drv = {3'h0, v[i]};
         #80 spi_clk = 1'b1;
         #80 spi_clk = 1'b0;
      end
   endtask : send
   // sampled late in the high phase to cover the device's lag
   task recv(input int lanes, input int n, output logic [31:0] d);
      d = 32'h0;
      host_oe = 4'h0;
      for (int i = 0; i < n; i++) begin
         #80 spi_clk = 1'b1;
         #80 d = (d << lanes) | (lanes == 4 ? {28'h0, io_in} :
            lanes == 2 ? {30'h0, io_in[1:0]} : {31'h0, io_in[1]});
         spi_clk = 1'b0;
      end
   endtask : recv
   task frame_end();
      #80 cs_n = 1'b1;
      host_oe = 4'h0;
      #320;
   endtask : frame_end
endmodule : spi_host_model

// ===== verilog/flash_cmd_seq.sv
// serial flash command sequencer: status, write-enable and output-read instructions
// assumes an array read port on sys_clk with data one cycle after mem_rd,
// and that program/erase logic elsewhere reports array_busy and array_done
//
// Behaviour
// - volatile enable arms status write, latch untouched
// - write-disable clears the write enable latch
// - latch clears at reset and operation completion
// - 05h/35h/15h shift status 1/2/3 MSB first
// - status reads always accepted, repeat until deselect
// - only listed status bits are writable
// - lock bits sticky; volatile keeps protect_1 set
// - stored status write needs latch set first
// - volatile write needs 50h just before, latch 0
// - reset reloads stored status into live copy
// - stored write busy for write time, clears latch
// - volatile write lands quickly, busy stays 0
// - 01h with 16 bits writes registers 1 and 2
// - read takes 24-bit address, returns bytes MSB first
// - address increments after every output byte
// - read while busy is ignored
// - fast read adds eight dummy clocks
// - dual read returns two bits per clock
// - quad read only accepted with quad enable set
// - dual: odd bits on IO1, even on IO0
// - quad: high nibble then low nibble
// - write-enable sets the write enable latch
`timescale 1ns/1ps
module flash_cmd_seq #(
   parameter int STATUS_WRITE_CYCLES = flash_pkg::STATUS_WRITE_CYCLES_DEF
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // serial pins
   input wire logic spi_clk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   // array read port
   output logic [23:0] mem_addr,
   output logic mem_rd,
   input wire logic [7:0] mem_rdata,
   // neighbouring operations
   input wire logic array_busy,
   input wire logic array_done,
   input wire logic soft_reset,
   // status view
   output logic busy,
   output logic write_enable_latch,
   output logic quad_enable,
   output logic [7:0] status_reg1,
   output logic [7:0] status_reg2,
   output logic [7:0] status_reg3
);
   import flash_pkg::*;

   status_if st ();

   logic cs_n_s;
   logic [3:0] io_s;
   logic clk_rise;
   logic clk_fall;
   logic cs_rise;
   seq_state_t state_reg;
   logic [4:0] bit_cnt_reg;
   logic [7:0] op_reg;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [2:0] lane_reg;
   logic from_status_reg;
   logic [1:0] sr_sel_reg;
   logic single_ok_reg;
   logic [7:0] wsr_lo_reg;
   logic [7:0] wsr_hi_reg;
   logic [23:0] addr_reg;
   logic fetch_reg;
   logic capture_reg;
   logic [7:0] next_byte_reg;
   logic [7:0] out_sh_reg;
   logic [2:0] out_pos_reg;
   logic [3:0] io_out_reg;
   logic [3:0] io_oe_reg;
   logic wel_reg;
   logic vol_arm_reg;
   logic nv_pend_reg;
   logic vol_pend_reg;
   logic [WAIT_W-1:0] wait_reg;
   logic wr_pulse_reg;
   logic wr_nv_reg;
   logic [2:0] pend_sel_reg;
   logic [2:0][7:0] pend_data_reg;
   logic rx;
   logic fx;
   logic load_byte;
   logic [7:0] out_src;
   logic wsr_ok;

   pin_sync u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .spi_clk(spi_clk),
      .cs_n(cs_n),
      .io_in(io_in),
      .cs_n_sync(cs_n_s),
      .io_sync(io_s),
      .clk_rise(clk_rise),
      .clk_fall(clk_fall),
      .cs_rise(cs_rise)
   );

   status_file u_status (
      .sys_clk(sys_clk),
      .reset(reset),
      .st(st.owner)
   );

   // live status bytes; busy and the latch are not stored bits
   assign busy = nv_pend_reg | array_busy;
   assign status_reg1 = {st.sr_val[0][7:2], wel_reg, busy};
   assign status_reg2 = st.sr_val[1];
   assign status_reg3 = st.sr_val[2];
   assign quad_enable = st.sr_val[1][SR2_QE_BIT];
   assign write_enable_latch = wel_reg;

   // serial edges only count while selected
   assign rx = clk_rise & ~cs_n_s;
   assign fx = clk_fall & ~cs_n_s;
   assign shift_next = {shift_reg[6:0], io_s[0]};

   // instruction, address, dummy and write-data framing on rising edges
   always_ff @(posedge sys_clk) begin
      if (reset || cs_n_s) begin
         state_reg <= ST_OPCODE;
         bit_cnt_reg <= 5'h00;
         single_ok_reg <= 1'b0;
      end else if (rx) begin
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
         case (state_reg)
            ST_OPCODE: begin
               if (bit_cnt_reg == BYTE_LAST) begin
                  op_reg <= shift_next;
                  bit_cnt_reg <= 5'h00;
                  lane_reg <= LANE_SINGLE;
                  from_status_reg <= 1'b0;
                  state_reg <= ST_IGNORE;
                  if (shift_next == OP_RDSR1 || shift_next == OP_RDSR2 ||
                      shift_next == OP_RDSR3) begin
                     from_status_reg <= 1'b1;
                     sr_sel_reg <= (shift_next == OP_RDSR1) ? 2'h0 :
                                   (shift_next == OP_RDSR2) ? 2'h1 : 2'h2;
                     state_reg <= ST_DATA;
                  end else if (busy) begin
                     state_reg <= ST_IGNORE;
                  end else if (shift_next == OP_READ || shift_next == OP_FREAD) begin
                     state_reg <= ST_ADDR;
                  end else if (shift_next == OP_DREAD) begin
                     lane_reg <= LANE_DUAL;
                     state_reg <= ST_ADDR;
                  end else if (shift_next == OP_QREAD && quad_enable) begin
                     lane_reg <= LANE_QUAD;
                     state_reg <= ST_ADDR;
                  end else if (shift_next == OP_WRSR1 || shift_next == OP_WRSR2 ||
                               shift_next == OP_WRSR3) begin
                     state_reg <= ST_WSR;
                  end else begin
                     // quad read without enable also lands here and never drives
                     single_ok_reg <= 1'b1;
                  end
               end
            end
            ST_ADDR: begin
               if (bit_cnt_reg == ADDR_LAST) begin
                  bit_cnt_reg <= 5'h00;
                  state_reg <= (op_reg == OP_READ) ? ST_DATA : ST_DUMMY;
               end
            end
            ST_DUMMY: begin
               if (bit_cnt_reg == DUMMY_LAST) begin
                  state_reg <= ST_DATA;
               end
            end
            ST_WSR: begin
               if (bit_cnt_reg == BYTE_LAST) begin
                  wsr_lo_reg <= shift_next;
               end
               if (bit_cnt_reg == WORD_LAST) begin
                  wsr_hi_reg <= shift_next;
               end
               if (bit_cnt_reg == TWO_BYTES) begin
                  state_reg <= ST_IGNORE;
               end
            end
            ST_IGNORE: begin
               // extra clocks spoil a one-byte instruction
               single_ok_reg <= 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   // address shifting, array fetch one byte ahead, post-increment
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         addr_reg <= 24'h000000;
         fetch_reg <= 1'b0;
         capture_reg <= 1'b0;
         next_byte_reg <= 8'h00;
      end else begin
         fetch_reg <= 1'b0;
         capture_reg <= fetch_reg;
         if (rx && state_reg == ST_ADDR) begin
            addr_reg <= {addr_reg[22:0], io_s[0]};
            fetch_reg <= (bit_cnt_reg == ADDR_LAST);
         end else if (load_byte && !from_status_reg) begin
            fetch_reg <= 1'b1;
         end
         if (capture_reg) begin
            next_byte_reg <= mem_rdata;
            addr_reg <= addr_reg + 24'h000001;
         end
      end
   end

   assign mem_addr = addr_reg;
   assign mem_rd = fetch_reg;

   // byte boundary on a falling edge; status bytes are sampled live so busy polls
   assign load_byte = fx && state_reg == ST_DATA && out_pos_reg == 3'h0;
   assign out_src = from_status_reg ?
                    ((sr_sel_reg == 2'h0) ? status_reg1 :
                     (sr_sel_reg == 2'h1) ? status_reg2 : status_reg3) : next_byte_reg;

   // output shifter on falling edges; IO1 carries single-lane data
   always_ff @(posedge sys_clk) begin
      if (reset || cs_n_s) begin
         out_pos_reg <= 3'h0;
         out_sh_reg <= 8'h00;
         io_out_reg <= 4'h0;
         io_oe_reg <= 4'h0;
      end else if (fx && state_reg == ST_DATA) begin
         out_pos_reg <= out_pos_reg + lane_reg; // lanes 1/2/4 wrap at eight bits
         if (lane_reg == LANE_QUAD) begin
            io_out_reg <= load_byte ? out_src[7:4] : out_sh_reg[7:4];
            io_oe_reg <= 4'hF;
         end else if (lane_reg == LANE_DUAL) begin
            io_out_reg <= {2'h0, load_byte ? out_src[7:6] : out_sh_reg[7:6]};
            io_oe_reg <= 4'h3;
         end else begin
            io_out_reg <= {2'h0, load_byte ? out_src[7] : out_sh_reg[7], 1'b0};
            io_oe_reg <= 4'h2;
         end
         out_sh_reg <= (load_byte ? out_src : out_sh_reg) << lane_reg;
      end
   end

   assign io_out = io_out_reg;
   assign io_oe = io_oe_reg;

   // write enable latch and volatile arm; a latch set wins over a same-cycle clear, a soft reset clears the arm
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wel_reg <= 1'b0;
         vol_arm_reg <= 1'b0;
      end else begin
         if (array_done || soft_reset || (wr_pulse_reg && wr_nv_reg)) begin
            wel_reg <= 1'b0;
         end
         if (cs_rise) begin
            vol_arm_reg <= 1'b0;
            if (state_reg == ST_IGNORE && single_ok_reg) begin
               if (op_reg == OP_WRDI) begin
                  wel_reg <= 1'b0;
               end else if (op_reg == OP_WREN) begin
                  wel_reg <= 1'b1;
               end else if (op_reg == OP_VWREN) begin
                  vol_arm_reg <= 1'b1;
               end
            end
         end
         if (soft_reset) begin
            vol_arm_reg <= 1'b0;
         end
      end
   end

   // status write accepted only on a whole byte, or two bytes for 01h
   assign wsr_ok = state_reg == ST_WSR &&
                   (bit_cnt_reg == ONE_BYTE ||
                    (bit_cnt_reg == TWO_BYTES && op_reg == OP_WRSR1));

   // status write scheduling: timed stored write or quick volatile refresh
   always_ff @(posedge sys_clk) begin
      if (reset || soft_reset) begin
         nv_pend_reg <= 1'b0;
         vol_pend_reg <= 1'b0;
         wait_reg <= '0;
         wr_pulse_reg <= 1'b0;
         wr_nv_reg <= 1'b0;
         pend_sel_reg <= 3'h0;
         pend_data_reg <= '0;
      end else begin
         wr_pulse_reg <= 1'b0;
         if (cs_rise && wsr_ok && (wel_reg || vol_arm_reg)) begin
            nv_pend_reg <= wel_reg;
            vol_pend_reg <= ~wel_reg;
            wr_nv_reg <= wel_reg;
            wait_reg <= wel_reg ? WAIT_W'(STATUS_WRITE_CYCLES) : WAIT_W'(VOL_REFRESH_CYCLES);
            if (op_reg == OP_WRSR1) begin
               pend_sel_reg <= (bit_cnt_reg == TWO_BYTES) ? 3'h3 : 3'h1;
               pend_data_reg <= {8'h00, wsr_hi_reg, wsr_lo_reg};
            end else if (op_reg == OP_WRSR2) begin
               pend_sel_reg <= 3'h2;
               pend_data_reg <= {8'h00, wsr_lo_reg, 8'h00};
            end else begin
               pend_sel_reg <= 3'h4;
               pend_data_reg <= {wsr_lo_reg, 16'h0000};
            end
         end else if (nv_pend_reg || vol_pend_reg) begin
            wait_reg <= wait_reg - WAIT_W'(1);
            if (wait_reg == WAIT_W'(1)) begin
               nv_pend_reg <= 1'b0;
               vol_pend_reg <= 1'b0;
               wr_pulse_reg <= 1'b1;
            end
         end
      end
   end

   assign st.wr_en = wr_pulse_reg;
   assign st.wr_nv = wr_nv_reg;
   assign st.wr_sel = pend_sel_reg;
   assign st.wr_data = pend_data_reg;
   assign st.reload = soft_reset;

endmodule : flash_cmd_seq

// ===== verilog/flash_pkg.sv
// constants, types and helpers shared by the status/read command sequencer
// assumes one 50 MHz system clock; serial pins arrive asynchronous to it
package flash_pkg;

   // instruction codes
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_VWREN = 8'h50;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR1 = 8'h05;
   localparam logic [7:0] OP_RDSR2 = 8'h35;
   localparam logic [7:0] OP_RDSR3 = 8'h15;
   localparam logic [7:0] OP_WRSR1 = 8'h01;
   localparam logic [7:0] OP_WRSR2 = 8'h31;
   localparam logic [7:0] OP_WRSR3 = 8'h11;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FREAD = 8'h0B;
   localparam logic [7:0] OP_DREAD = 8'h3B;
   localparam logic [7:0] OP_QREAD = 8'h6B;

   // status register layout
   localparam int SR1_BUSY_BIT = 0;
   localparam int SR1_WEL_BIT = 1;
   localparam int SR2_QE_BIT = 1;
   localparam logic [7:0] SR1_WMASK = 8'hFC; // protect_0, sector, top/bottom, block_protect
   localparam logic [7:0] SR2_WMASK = 8'h7B; // complement, lock[3:1], quad_enable, protect_1
   localparam logic [7:0] SR3_WMASK = 8'hE6; // hold/reset, drive[1:0], wp select, addr mode
   localparam logic [7:0] SR2_NV_KEEP = 8'h38; // one-time lock bits never clear
   localparam logic [7:0] SR2_VOL_KEEP = 8'h39; // volatile write also keeps protect_1
   localparam logic [7:0] SR_NO_KEEP = 8'h00;

   // stored values restored at power-up
   localparam logic [7:0] SR1_NV_INIT = 8'h00;
   localparam logic [7:0] SR2_NV_INIT = 8'h00;
   localparam logic [7:0] SR3_NV_INIT = 8'h60;

   // serial framing, counted in serial clocks
   localparam logic [4:0] BYTE_LAST = 5'h07;
   localparam logic [4:0] WORD_LAST = 5'h0F;
   localparam logic [4:0] ADDR_LAST = 5'h17;
   localparam logic [4:0] DUMMY_LAST = 5'h07;
   localparam logic [4:0] ONE_BYTE = 5'h08;
   localparam logic [4:0] TWO_BYTES = 5'h10;

   // output lane widths (bits per serial clock)
   localparam logic [2:0] LANE_SINGLE = 3'h1;
   localparam logic [2:0] LANE_DUAL = 3'h2;
   localparam logic [2:0] LANE_QUAD = 3'h4;

   // timing
   localparam int SYS_CLK_MHZ = 50;
   localparam int SYS_CLK_PERIOD_NS = 20;
   localparam int STATUS_WRITE_TIME_US = 10000;
   localparam int STATUS_WRITE_CYCLES_DEF = STATUS_WRITE_TIME_US * SYS_CLK_MHZ;
   localparam int VOLATILE_REFRESH_TIME_NS = 50;
   localparam int VOL_REFRESH_RAW = VOLATILE_REFRESH_TIME_NS / SYS_CLK_PERIOD_NS;
   localparam int VOL_REFRESH_CYCLES = (VOL_REFRESH_RAW < 1) ? 1 : VOL_REFRESH_RAW;
   localparam int WAIT_W = 24;

   // sequencer states, gray along opcode -> addr -> dummy -> data
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b011,
      ST_DATA = 3'b010,
      ST_WSR = 3'b110,
      ST_IGNORE = 3'b100
   } seq_state_t;

   // merge written data into writable bits, keeping sticky ones set
   function automatic logic [7:0] merge_status(input logic [7:0] old, input logic [7:0] data,
                                               input logic [7:0] wmask, input logic [7:0] keep);
      merge_status = (old & ~wmask) | (data & wmask) | (old & keep);
   endfunction : merge_status

endpackage : flash_pkg

// ===== verilog/pin_sync.sv
// two-flop synchronisers for the serial pins plus clock and select edge finders
// assumes pins are asynchronous to sys_clk and the serial clock is far slower
`timescale 1ns/1ps
module pin_sync (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // raw pins
   input wire logic spi_clk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   // synchronised view
   output logic cs_n_sync,
   output logic [3:0] io_sync,
   output logic clk_rise,
   output logic clk_fall,
   output logic cs_rise
);
   logic [5:0] meta_reg;
   logic [5:0] sync_reg;
   logic clk_prev_reg;
   logic cs_prev_reg;

   // only sync_reg reads meta_reg
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         meta_reg <= 6'h02;
         sync_reg <= 6'h02;
      end else begin
         meta_reg <= {io_in, cs_n, spi_clk};
         sync_reg <= meta_reg;
      end
   end

   // previous values for edge detection
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         clk_prev_reg <= 1'b0;
         cs_prev_reg <= 1'b1;
      end else begin
         clk_prev_reg <= sync_reg[0];
         cs_prev_reg <= sync_reg[1];
      end
   end

   assign cs_n_sync = sync_reg[1];
   assign io_sync = sync_reg[5:2];
   assign clk_rise = sync_reg[0] & ~clk_prev_reg;
   assign clk_fall = ~sync_reg[0] & clk_prev_reg;
   assign cs_rise = sync_reg[1] & ~cs_prev_reg;

endmodule : pin_sync

// ===== verilog/status_file.sv
// stored and live copies of the three status registers
// assumes writes arrive already qualified by the sequencer
`timescale 1ns/1ps
module status_file (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // sequencer side
   status_if.owner st
);
   import flash_pkg::*;

   logic [2:0][7:0] nv_reg;
   logic [2:0][7:0] vol_reg;

   function automatic logic [7:0] wmask_of(input int i);
      wmask_of = (i == 0) ? SR1_WMASK : (i == 1) ? SR2_WMASK : SR3_WMASK;
   endfunction : wmask_of

   // stored copy: only touched by a timed non-volatile write
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         nv_reg <= {SR3_NV_INIT, SR2_NV_INIT, SR1_NV_INIT};
      end else if (st.wr_en && st.wr_nv) begin
         for (int i = 0; i < 3; i++) begin
            if (st.wr_sel[i]) begin
               nv_reg[i] <= merge_status(nv_reg[i], st.wr_data[i], wmask_of(i),
                                         (i == 1) ? SR2_NV_KEEP : SR_NO_KEEP);
            end
         end
      end
   end

   // live copy: follows stored writes, takes volatile writes, reloads on soft reset
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         vol_reg <= {SR3_NV_INIT, SR2_NV_INIT, SR1_NV_INIT};
      end else if (st.reload) begin
         vol_reg <= nv_reg;
      end else if (st.wr_en) begin
         for (int i = 0; i < 3; i++) begin
            if (st.wr_sel[i] && st.wr_nv) begin
               vol_reg[i] <= merge_status(nv_reg[i], st.wr_data[i], wmask_of(i),
                                          (i == 1) ? SR2_NV_KEEP : SR_NO_KEEP);
            end else if (st.wr_sel[i]) begin
               vol_reg[i] <= merge_status(vol_reg[i], st.wr_data[i], wmask_of(i),
                                          (i == 1) ? SR2_VOL_KEEP : SR_NO_KEEP);
            end
         end
      end
   end

   assign st.sr_val = vol_reg;

endmodule : status_file

// ===== verilog/status_if.sv
// carrier between the command sequencer and the status register file
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface status_if;
   logic wr_en;
   logic wr_nv;
   logic [2:0] wr_sel;
   logic [2:0][7:0] wr_data;
   logic reload;
   logic [2:0][7:0] sr_val;

   modport owner (input wr_en, input wr_nv, input wr_sel, input wr_data, input reload,
                  output sr_val);
   modport user (output wr_en, output wr_nv, output wr_sel, output wr_data, output reload,
                 input sr_val);
endinterface : status_if
